// ---- design/reset_timer_watchdog_unit.v ----
// reset cause sorting, device reset timer and watchdog with prescaler
// assumes one 25 MHz clock, synchronous rst as power-on, axi4-lite master on the same clock
//
// Notes on behaviour
// - seven reset causes are told apart and reported.
// - registers without reset value keep contents across every reset.
// - ordinary registers reload on por, pin reset, watchdog or pin wake while running.
// - pin or watchdog reset during sleep resumes; option and direction kept, cause flags change.
// - status 00-1 1xxx at power-on; 000u uuuu after running pin reset.
// - pin reset in sleep gives status 0001 0uuu.
// - watchdog reset in sleep clears the upper five status bits.
// - watchdog reset while running gives 0000 uuuu.
// - pin-change wake gives upper nibble 1001.
// - comparator-change wake gives upper nibble 0101.
// - every reset forces program counter low byte to all ones.
// - pointer top bits ones; trim fe at por; option and direction ones except after pin or watchdog reset in sleep.
// - accumulator upper six bits take calibration content after any reset.
// - pin enable fuse at one enables pin reset; otherwise input tied inactive.
// - power-up sets reset latch, clears timer; expiry clears latch.
// - timer counts only while reset input high; core held while timer active.
// - timer holds 18 ms after power-on, 10 us after later resets.
// - timer started by por, pin reset, watchdog timeout and pin wake.
// - watchdog keeps counting while the core sleeps.
// - watchdog timeout resets in run and sleep and clears timeout flag.
// - watchdog fuse at zero disables it permanently.
// - base timeout 18 ms; prescaler up to 1:128.
// - clear op zeroes watchdog counter and assigned prescaler.
// - sleep op zeroes watchdog counter and assigned prescaler.
// - powerdown flag set at power-up, cleared by sleep.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "rst_wdt_map.vh"

module reset_timer_watchdog_unit #(
   parameter DRT_POR_CYCLES = (`CLK_HZ / 1000) * `DRT_POR_US / 1000,
   parameter WDT_BASE_CYCLES = (`CLK_HZ / 1000) * `WDT_BASE_US / 1000,
   parameter [7:0] CAL_WORD = 8'hA4
) (
   // clock, reset, enable
   input wire clk_sys,
   input wire rst,
   input wire clk_en,
   // pins and fuses
   input wire ext_reset_pin_n,
   input wire ext_reset_pin_enable,
   input wire watchdog_enable_fuse,
   // core side
   output wire core_reset,
   output reg [7:0] pc_low_byte,
   output reg [7:0] indirect_pointer,
   output reg [7:0] osc_trim,
   output reg [3:0] pin_direction,
   output reg [7:0] acc_w,
   output reg [2:0] reset_cause,
   // axi4-lite slave
   input wire [7:0] s_awaddr,
   input wire s_awvalid,
   output wire s_awready,
   input wire [31:0] s_wdata,
   input wire [3:0] s_wstrb,
   input wire s_wvalid,
   output wire s_wready,
   output reg [1:0] s_bresp,
   output reg s_bvalid,
   input wire s_bready,
   input wire [7:0] s_araddr,
   input wire s_arvalid,
   output wire s_arready,
   output reg [31:0] s_rdata,
   output reg [1:0] s_rresp,
   output reg s_rvalid,
   input wire s_rready
);

   // ====================================================================
   // timing
   localparam DRT_SUB_CYCLES = (`CLK_HZ / 1000) * `DRT_SUB_NS / 1000000;
   localparam [22:0] DRT_POR_LEN = DRT_POR_CYCLES[22:0];
   localparam [22:0] DRT_SUB_LEN = DRT_SUB_CYCLES[22:0];
   localparam [19:0] WDT_LEN = WDT_BASE_CYCLES[19:0];

   // fsm states
   localparam [2:0] S_HOLD = 3'b001;
   localparam [2:0] S_RUN = 3'b010;
   localparam [2:0] S_SLEEP = 3'b100;

   function [2:0] cause_sel(input asleep, input [2:0] run_c, input [2:0] slp_c);
      cause_sel = asleep ? slp_c : run_c;
   endfunction

   // ====================================================================
   // pin synchroniser and fuse gating
   reg pin_s1_q, pin_s2_q, pin_prev_q;
   wire ext_reset_pin_high = pin_s2_q | ~ext_reset_pin_enable;
   wire pin_fall = ~ext_reset_pin_high & pin_prev_q;
   always @(posedge clk_sys) begin
      if (rst) begin
         pin_s1_q <= 1'b1;
         pin_s2_q <= 1'b1;
         pin_prev_q <= 1'b1;
      end else if (clk_en) begin
         pin_s1_q <= ext_reset_pin_n;
         pin_s2_q <= pin_s1_q;
         pin_prev_q <= ext_reset_pin_high;
      end
   end

   // ====================================================================
   // registers and bus decode
   reg [2:0] state_q;
   reg [22:0] drt_q;
   reg drt_por_q;
   reg [19:0] wdt_q;
   reg [6:0] pre_q;
   reg [7:0] status_q;
   reg [7:0] option_q;
   reg aw_q, w_q;
   reg [7:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;

   assign s_awready = ~aw_q & ~s_bvalid;
   assign s_wready = ~w_q & ~s_bvalid;
   assign s_arready = ~s_rvalid;
   wire wr_go = aw_q & w_q & ~s_bvalid;
   wire [7:0] wr_addr = awaddr_q;
   wire ctl_wr = wr_go & (wr_addr == `ADDR_CTRL) & wstrb_q[0];
   wire do_clr = ctl_wr & wdata_q[`CTL_CLEAR_WDT] & (state_q == S_RUN);
   wire do_sleep = ctl_wr & wdata_q[`CTL_SLEEP] & (state_q == S_RUN);
   wire do_pwake = ctl_wr & wdata_q[`CTL_PIN_WAKE] & (state_q == S_SLEEP);
   wire do_cwake = ctl_wr & wdata_q[`CTL_CMP_WAKE] & (state_q == S_SLEEP);
   assign core_reset = (state_q == S_HOLD);

   // ====================================================================
   // watchdog with shared prescaler
   wire prescaler_assign = option_q[`OPT_PSA];
   wire [2:0] rate = option_q[`OPT_RATE_HI:`OPT_RATE_LO];
   wire [6:0] pre_max = prescaler_assign ? ((7'h01 << rate) - 7'h01) : 7'h00;
   wire wdt_on = watchdog_enable_fuse;
   wire wdt_tick = wdt_on & (state_q != S_HOLD) & (wdt_q == WDT_LEN - 20'h00001);
   wire wdt_fire = wdt_tick & (pre_q == pre_max);

   // ====================================================================
   // reset event classification
   reg [2:0] ev;
   always @* begin
      ev = `CAUSE_NONE;
      if (state_q != S_HOLD) begin
         if (pin_fall)
            ev = cause_sel(state_q == S_SLEEP, `CAUSE_PIN_RUN, `CAUSE_PIN_SLP);
         else if (wdt_fire)
            ev = cause_sel(state_q == S_SLEEP, `CAUSE_WDT_RUN, `CAUSE_WDT_SLP);
         else if (do_pwake)
            ev = `CAUSE_PIN_WAKE;
         else if (do_cwake)
            ev = `CAUSE_CMP_WAKE;
      end
   end
   wire any_ev = (ev != `CAUSE_NONE);
   // sleep-time pin and watchdog resets resume, ordinary registers kept
   wire resume = (ev == `CAUSE_PIN_SLP) | (ev == `CAUSE_WDT_SLP);

   // ====================================================================
   // reset sequencer
   always @(posedge clk_sys) begin
      if (rst) begin
         state_q <= S_HOLD;
         drt_q <= 23'd0;
         drt_por_q <= 1'b1;
         reset_cause <= `CAUSE_POR;
      end else if (clk_en) begin
         case (state_q)
            S_HOLD: begin
               if (!ext_reset_pin_high)
                  drt_q <= 23'd0;
               else if (drt_q >= (drt_por_q ? DRT_POR_LEN : DRT_SUB_LEN) - 23'd1) begin
                  state_q <= S_RUN;
                  drt_q <= 23'd0;
                  drt_por_q <= 1'b0;
               end else
                  drt_q <= drt_q + 23'd1;
            end
            S_RUN, S_SLEEP: begin
               if (any_ev) begin
                  state_q <= S_HOLD;
                  drt_q <= 23'd0;
                  reset_cause <= ev;
               end else if (do_sleep)
                  state_q <= S_SLEEP;
            end
            default: state_q <= S_HOLD;
         endcase
      end
   end

   // watchdog counter and prescaler
   always @(posedge clk_sys) begin
      if (rst) begin
         wdt_q <= 20'd0;
         pre_q <= 7'd0;
      end else if (clk_en) begin
         if (!wdt_on || do_clr || do_sleep || any_ev || state_q == S_HOLD) begin
            wdt_q <= 20'd0;
            pre_q <= 7'd0;
         end else if (wdt_tick) begin
            wdt_q <= 20'd0;
            pre_q <= (pre_q == pre_max) ? 7'd0 : pre_q + 7'd1;
         end else
            wdt_q <= wdt_q + 20'd1;
      end
   end

   // ====================================================================
   // status flags and core register reset values
   always @(posedge clk_sys) begin
      if (rst) begin
         status_q <= `ST_POR_VAL;
         option_q <= `ONES8;
         pc_low_byte <= `ONES8;
         indirect_pointer <= `PTR_TOP;
         osc_trim <= `TRIM_POR;
         pin_direction <= `PIN_DIR_ONES;
         acc_w <= {CAL_WORD[7:2], 2'b00};
      end else if (clk_en) begin
         if (any_ev) begin
            pc_low_byte <= `ONES8;
            acc_w <= {CAL_WORD[7:2], acc_w[1:0]};
            indirect_pointer <= indirect_pointer | `PTR_TOP;
            option_q <= `ONES8;
            pin_direction <= `PIN_DIR_ONES;
            status_q[`ST_PIN_WAKE] <= (ev == `CAUSE_PIN_WAKE);
            status_q[`ST_CMP_WAKE] <= (ev == `CAUSE_CMP_WAKE);
            status_q[`ST_RSVD] <= 1'b0;
            case (ev)
               `CAUSE_PIN_SLP: begin
                  status_q[`ST_TIMEOUT] <= 1'b1;
                  status_q[`ST_POWERDOWN] <= 1'b0;
               end
               `CAUSE_WDT_SLP: begin
                  status_q[`ST_TIMEOUT] <= 1'b0;
                  status_q[`ST_POWERDOWN] <= 1'b0;
               end
               `CAUSE_WDT_RUN: status_q[`ST_TIMEOUT] <= 1'b0;
               `CAUSE_PIN_WAKE, `CAUSE_CMP_WAKE: begin
                  status_q[`ST_TIMEOUT] <= 1'b1;
                  status_q[`ST_POWERDOWN] <= 1'b0;
               end
               default: ; // running pin reset keeps low five bits
            endcase
            if (resume) begin
               option_q <= option_q;
               pin_direction <= pin_direction;
            end
         end else begin
            if (do_sleep) begin
               status_q[`ST_TIMEOUT] <= 1'b1;
               status_q[`ST_POWERDOWN] <= 1'b0;
            end
            if (wr_go && wr_addr == `ADDR_STATUS && wstrb_q[0])
               status_q[2:0] <= wdata_q[2:0];
            if (wr_go && wr_addr == `ADDR_OPTION && wstrb_q[0])
               option_q <= wdata_q[7:0];
            if (wr_go && wr_addr == `ADDR_TRIM && wstrb_q[0])
               osc_trim <= wdata_q[7:0];
            if (wr_go && wr_addr == `ADDR_W && wstrb_q[0])
               acc_w <= wdata_q[7:0];
         end
      end
   end

   // ====================================================================
   // axi4-lite write and read channels
   always @(posedge clk_sys) begin
      if (rst) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_bvalid <= 1'b0;
         s_bresp <= `RESP_OKAY;
         s_rvalid <= 1'b0;
         s_rresp <= `RESP_OKAY;
         s_rdata <= 32'h0000_0000;
      end else if (clk_en) begin
         if (s_awvalid && s_awready) begin
            aw_q <= 1'b1;
            awaddr_q <= {s_awaddr[`ADDR_MSB:2], 2'b00};
         end
         if (s_wvalid && s_wready) begin
            w_q <= 1'b1;
            wdata_q <= s_wdata;
            wstrb_q <= s_wstrb;
         end
         if (wr_go) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            s_bvalid <= 1'b1;
            case (wr_addr)
               `ADDR_CTRL, `ADDR_STATUS, `ADDR_OPTION, `ADDR_TRIM, `ADDR_W: s_bresp <= `RESP_OKAY;
               default: s_bresp <= `RESP_SLVERR;
            endcase
         end else if (s_bvalid && s_bready)
            s_bvalid <= 1'b0;
         if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rresp <= `RESP_OKAY;
            case ({s_araddr[`ADDR_MSB:2], 2'b00})
               `ADDR_CTRL: s_rdata <= {29'd0, state_q};
               `ADDR_STATUS: s_rdata <= {24'd0, status_q};
               `ADDR_OPTION: s_rdata <= {24'd0, option_q};
               `ADDR_CAUSE: s_rdata <= {29'd0, reset_cause};
               `ADDR_CORE: s_rdata <= {16'd0, pc_low_byte, indirect_pointer};
               `ADDR_TRIM: s_rdata <= {24'd0, osc_trim};
               `ADDR_W: s_rdata <= {24'd0, acc_w};
               default: begin
                  s_rdata <= 32'h0000_0000;
                  s_rresp <= `RESP_SLVERR;
               end
            endcase
         end else if (s_rvalid && s_rready)
            s_rvalid <= 1'b0;
      end
   end

endmodule // reset_timer_watchdog_unit

// ---- design/rst_wdt_map.vh ----
// register map, field positions, reset values and timing figures for the reset/watchdog unit
// assumes inclusion by bare name from the design file; definitions only
`ifndef RST_WDT_MAP_VH
`define RST_WDT_MAP_VH

// byte addresses on the axi4-lite slave
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h0C
`define ADDR_OPTION 8'h10
`define ADDR_CAUSE 8'h14
`define ADDR_CORE 8'h18
`define ADDR_TRIM 8'h1C
`define ADDR_W 8'h20
`define ADDR_MSB 7

// status register fields
`define ST_PIN_WAKE 7
`define ST_CMP_WAKE 6
`define ST_RSVD 5
`define ST_TIMEOUT 4
`define ST_POWERDOWN 3
`define ST_POR_VAL 8'h18
`define ST_CMD_CLR 8'h00

// control register command bits (write one to act)
`define CTL_CLEAR_WDT 0
`define CTL_SLEEP 1
`define CTL_PIN_WAKE 2
`define CTL_CMP_WAKE 3

// option register fields
`define OPT_PSA 3
`define OPT_RATE_HI 2
`define OPT_RATE_LO 0

// reset values
`define ONES8 8'hFF
`define TRIM_POR 8'hFE
`define PTR_TOP 8'hE0
`define PIN_DIR_ONES 4'hF

// cause codes
`define CAUSE_NONE 3'h0
`define CAUSE_POR 3'h1
`define CAUSE_PIN_RUN 3'h2
`define CAUSE_PIN_SLP 3'h3
`define CAUSE_WDT_RUN 3'h4
`define CAUSE_WDT_SLP 3'h5
`define CAUSE_PIN_WAKE 3'h6
`define CAUSE_CMP_WAKE 3'h7

// timing (clk_sys 25 MHz)
`define CLK_HZ 25000000
`define DRT_POR_US 18000
`define DRT_SUB_NS 10000
`define WDT_BASE_US 18000

// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ---- sim/board_reset_model.sv ----
// board reset circuit on the external reset pin
// assumes a pull-up on the pin; the bench asks for presses
`timescale 1ns/1ps
module board_reset_model (
   // clock
   input wire clk_sys,
   // press request
   input wire press,
   // pin
   output logic ext_reset_pin_n
);
   // pull-up gives high when released
   initial ext_reset_pin_n = 1'h1;
   always @(posedge clk_sys) begin
      ext_reset_pin_n <= !press;
   end
endmodule // board_reset_model

// ---- sim/rtwu_chk.sv ----
// port checker for reset_timer_watchdog_unit
// assumes clk_en held high; bound in at the foot of this file
`timescale 1ns/1ps
module rtwu_chk #(
   parameter DRT_POR_CYCLES = 50,
   parameter [7:0] CAL_WORD = 8'h00
) (
   // clock and reset
   input wire clk_sys,
   input wire rst,
   // pin and fuse
   input wire ext_reset_pin_n,
   input wire ext_reset_pin_enable,
   // core side
   input wire core_reset,
   input wire [7:0] pc_low_byte,
   input wire [7:0] indirect_pointer,
   input wire [7:0] osc_trim,
   input wire [7:0] acc_w,
   input wire [2:0] reset_cause,
   // write response
   input wire [1:0] s_bresp,
   input wire s_bvalid
);
   localparam int SUB_CYC = 250;
   logic [19:0] hold_q;
   logic por_q;
   // ==========
   // hold length, restarted while the pin is low
   always @(posedge clk_sys) begin
      if (rst || !core_reset || (ext_reset_pin_enable && !ext_reset_pin_n)) begin
         hold_q <= 20'h0_0000;
      end else begin
         hold_q <= hold_q + 20'h0_0001;
      end
      por_q <= rst | (por_q & core_reset);
   end
   // ==========
   // properties
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   property p_por_hold; $fell(rst) |-> core_reset; endproperty
   property p_pin_hold; (ext_reset_pin_enable && !ext_reset_pin_n) [*6] |-> core_reset; endproperty
   property p_drt_len; $fell(core_reset) |-> hold_q >= (por_q ? DRT_POR_CYCLES : SUB_CYC); endproperty
   property p_pc_ones; $rose(core_reset) |=> pc_low_byte == 8'hFF; endproperty
   property p_ptr_top; $rose(core_reset) |=> indirect_pointer[7:5] == 3'h7; endproperty
   property p_trim_por; core_reset && por_q |-> osc_trim == 8'hFE; endproperty
   property p_acc_cal; $fell(core_reset) |-> acc_w[7:2] == CAL_WORD[7:2]; endproperty
   property p_cause_set; $fell(core_reset) |-> reset_cause != 3'h0; endproperty
   a_por_hold: assert property (p_por_hold) else $error("core free at reset exit");
   a_pin_hold: assert property (p_pin_hold) else $error("core free with pin low");
   a_drt_len: assert property (p_drt_len) else $error("hold too short");
   a_pc_ones: assert property (p_pc_ones) else $error("pc low not ones");
   a_ptr_top: assert property (p_ptr_top) else $error("pointer top not ones");
   a_trim_por: assert property (p_trim_por) else $error("trim wrong at power-on");
   a_acc_cal: assert property (p_acc_cal) else $error("acc without calibration");
   a_cause_set: assert property (p_cause_set) else $error("no cause at release");
   c_wdt_sleep: cover property (!core_reset && reset_cause == 3'h5);
   c_cmp_wake: cover property (!core_reset && reset_cause == 3'h7);
   c_slverr: cover property (s_bvalid && s_bresp == 2'h2);
endmodule // rtwu_chk
bind reset_timer_watchdog_unit rtwu_chk #(.DRT_POR_CYCLES(DRT_POR_CYCLES), .CAL_WORD(CAL_WORD)) u_chk (
   .clk_sys, .rst, .ext_reset_pin_n, .ext_reset_pin_enable, .core_reset, .pc_low_byte,
   .indirect_pointer, .osc_trim, .acc_w, .reset_cause, .s_bresp, .s_bvalid);

// ---- sim/tb_reset_timer_watchdog_unit.sv ----
// bench for reset_timer_watchdog_unit
// assumes the map header on the include path and the bound checker
`timescale 1ns/1ps
`include "rst_wdt_map.vh"
module tb_reset_timer_watchdog_unit;
   localparam [7:0] CAL = 8'h5C;
   logic clk_sys = 1'h0, rst = 1'h1, press = 1'h1, pin_en = 1'h1, wdt_en = 1'h1;
   logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0;
   logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
   logic [31:0] s_wdata = 32'h0000_0000;
   logic [31:0] d;
   logic [1:0] r;
   int mismatches = 0, checks = 0, cyc = 0, n;
   wire s_awready, s_wready, s_bvalid, s_arready, s_rvalid, ext_reset_pin_n, core_reset;
   wire [1:0] s_bresp, s_rresp;
   wire [31:0] s_rdata;
   wire [7:0] pc_low_byte, indirect_pointer, osc_trim, acc_w;
   wire [3:0] pin_direction;
   wire [2:0] reset_cause;
   always #20 clk_sys = ~clk_sys;
   board_reset_model board (.clk_sys, .press, .ext_reset_pin_n);
   reset_timer_watchdog_unit #(.DRT_POR_CYCLES(50), .WDT_BASE_CYCLES(20), .CAL_WORD(CAL)) dut (
      .clk_sys, .rst, .clk_en(1'h1), .ext_reset_pin_n, .ext_reset_pin_enable(pin_en),
      .watchdog_enable_fuse(wdt_en), .core_reset, .pc_low_byte, .indirect_pointer, .osc_trim,
      .pin_direction, .acc_w, .reset_cause, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
      .s_wstrb(4'h1), .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
      .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
   // ==========
   // shared tasks
   task automatic conclude();
      if (mismatches == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic ah, wh, bh;
      @(posedge clk_sys);
      s_awaddr <= a;
      s_wdata <= v;
      s_awvalid <= 1'h1;
      s_wvalid <= 1'h1;
      s_bready <= 1'h1;
      bh = 1'h0;
      while (!bh) begin
         @(negedge clk_sys);
         ah = s_awvalid & s_awready;
         wh = s_wvalid & s_wready;
         bh = s_bvalid;
         rs = s_bresp;
         @(posedge clk_sys);
         if (ah) s_awvalid <= 1'h0;
         if (wh) s_wvalid <= 1'h0;
      end
      s_bready <= 1'h0;
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      logic ah, rh;
      @(posedge clk_sys);
      s_araddr <= a;
      s_arvalid <= 1'h1;
      s_rready <= 1'h1;
      rh = 1'h0;
      while (!rh) begin
         @(negedge clk_sys);
         ah = s_arvalid & s_arready;
         rh = s_rvalid;
         v = s_rdata;
         rs = s_rresp;
         @(posedge clk_sys);
         if (ah) s_arvalid <= 1'h0;
      end
      s_rready <= 1'h0;
   endtask
   task automatic wcr(input logic lvl, input int lim);
      n = 0;
      while (core_reset !== lvl && n < lim) begin
         @(negedge clk_sys);
         n++;
      end
      chk(core_reset, lvl);
   endtask
   task automatic bounce();
      wcr(1'h1, 100);
      wcr(1'h0, 400);
   endtask
   task automatic pulse();
      @(posedge clk_sys);
      press <= 1'h1;
      repeat (8) @(posedge clk_sys);
      press <= 1'h0;
   endtask
   task automatic res(input logic [2:0] c, input logic [7:0] st);
      chk(reset_cause, c);
      chk(pc_low_byte, 8'hFF);
      chk(indirect_pointer[7:5], 3'h7);
      chk(acc_w[7:2], CAL[7:2]);
      axr(`ADDR_STATUS, d, r);
      chk(d[7:3], st[7:3]);
   endtask
   // ==========
   // scenarios
   task automatic t_por();
      repeat (20) @(posedge clk_sys);
      chk(core_reset, 1'h1);
      press <= 1'h0;
      wcr(1'h0, 200);
      chk(osc_trim, 8'hFE);
      chk(pin_direction, 4'hF);
      res(`CAUSE_POR, 8'h18);
      axr(`ADDR_OPTION, d, r);
      chk(d[3:0], 4'hF);
   endtask
   task automatic t_pin_run();
      axw(`ADDR_STATUS, 32'h0000_0005, r);
      axw(`ADDR_TRIM, 32'h0000_0033, r);
      axw(`ADDR_OPTION, 32'h0000_000E, r);
      pulse();
      bounce();
      res(`CAUSE_PIN_RUN, 8'h18);
      chk(d[2:0], 3'h5);
      chk(osc_trim, 8'h33);
      axr(`ADDR_OPTION, d, r);
      chk(d[3:0], 4'hF);
   endtask
   task automatic t_wdt_run();
      axw(`ADDR_CTRL, 32'h0000_0001, r);
      axw(`ADDR_OPTION, 32'h0000_0009, r);
      axw(`ADDR_CTRL, 32'h0000_0001, r);
      repeat (25) @(posedge clk_sys);
      axw(`ADDR_CTRL, 32'h0000_0001, r);
      wcr(1'h1, 100);
      chk(n > 34 && n < 46, 1'h1);
      wcr(1'h0, 400);
      res(`CAUSE_WDT_RUN, 8'h08);
   endtask
   task automatic nap(input logic [3:0] wake, input logic pin, input logic [7:0] opt,
                      input logic [3:0] eopt, input logic [2:0] c, input logic [7:0] st);
      axw(`ADDR_CTRL, 32'h0000_0001, r);
      axw(`ADDR_OPTION, {24'h00_0000, opt}, r);
      axw(`ADDR_CTRL, 32'h0000_0002, r);
      axr(`ADDR_STATUS, d, r);
      chk(d[4:3], 2'h2);
      if (wake != 4'h0) axw(`ADDR_CTRL, {28'h000_0000, wake}, r);
      if (pin) pulse();
      bounce();
      res(c, st);
      axr(`ADDR_OPTION, d, r);
      chk(d[3:0], eopt);
   endtask
   task automatic t_fuses();
      pin_en <= 1'h0;
      wdt_en <= 1'h0;
      axw(`ADDR_OPTION, 32'h0000_0008, r);
      pulse();
      repeat (100) @(posedge clk_sys);
      chk(core_reset, 1'h0);
      chk(reset_cause, `CAUSE_WDT_SLP);
   endtask
   task automatic t_unmapped();
      axr(8'h40, d, r);
      chk(r, `RESP_SLVERR);
      chk(d, 32'h0000_0000);
      axw(8'h44, 32'h0000_0001, r);
      chk(r, `RESP_SLVERR);
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 10000) begin
         mismatches++;
         conclude();
      end
   end
   initial begin
      repeat (10) @(posedge clk_sys);
      rst <= 1'h0;
      t_por();
      t_pin_run();
      t_wdt_run();
      nap(4'h4, 1'h0, 8'h0E, 4'hF, `CAUSE_PIN_WAKE, 8'h90);
      nap(4'h8, 1'h0, 8'h0F, 4'hF, `CAUSE_CMP_WAKE, 8'h50);
      nap(4'h0, 1'h1, 8'h0E, 4'hE, `CAUSE_PIN_SLP, 8'h10);
      nap(4'h0, 1'h0, 8'h08, 4'h8, `CAUSE_WDT_SLP, 8'h00);
      t_fuses();
      t_unmapped();
      conclude();
   end
endmodule // tb_reset_timer_watchdog_unit
